// >>> shared/cgsm_pkg.sv
// Package for the clock generator serial configuration slave.
// Assumes a single system clock domain; the serial link is sampled.
package cgsm_pkg;
  localparam logic [7:0] SLAVE_ADDR_WR = 8'hD2;
  localparam int CFG_BYTES = 8;
  localparam logic [5:0] MAX_COUNT = 6'h20;
  localparam logic [7:0] CFG0_RESET = 8'h0F;
  localparam logic [7:0] CFG1_RESET = 8'hFF;
  localparam logic [7:0] CFG2_RESET = 8'hFE;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  localparam int SPREAD_BIT = 3;
  localparam int DOT_BIT = 2;
  localparam int BUS48_BIT = 1;
  localparam int HOST2_BIT = 0;
  localparam int GFX_BIT = 7;
  localparam int MEM133_BIT = 0;
  localparam int SPREAD_PERMILLE = -5;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_BYTE = 5'h04,
    ST_ACK = 5'h08,
    ST_IGNORE = 5'h10
  } cgsm_state_t;

  typedef struct packed {
    logic spreadOn;
    logic dotEn;
    logic bus48En;
    logic hostClockTwoTestPortEn;
    logic [7:0] memoryClockOutputsEn;
    logic graphicsFixed66ClockEn;
    logic [6:1] expansionBusClockOutputsEn;
    logic mem133Mode;
  } cgsm_ctrl_t;
endpackage

// >>> logic/cgsm_slave.sv
// Serial configuration slave of the clock generator: accepts block writes
// only and drives the output enables. Expects the bus clock and data pins
// asynchronous to sys_clk, with sys_clk far faster than the bus clock.
`timescale 1ns/10ps
module cgsm_slave
  import cgsm_pkg::*;
(
  input wire logic sys_clk, // System clock, 40 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic serialClockLine, // Bus clock pin
  input wire logic serialDataLineIn, // Data pin level
  output logic serialDataLineOut, // Data pin drive value, always low
  output logic serialDataLineOen_n, // Data pin enable, low drives
  output cgsm_ctrl_t ctrl, // Applied configuration
  output logic transferValid, // Pulse when byte count acknowledged
  output logic [7:0] cfgByte3 // Byte three as written
);
  logic rstA_q, rstB_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstA_q <= 1'b0;
      rstB_q <= 1'b0;
    end else begin
      rstA_q <= 1'b1;
      rstB_q <= rstA_q;
    end
  end
  wire rstN = rstB_q;

  // Two-flop synchronisers, then a third and a fourth stage for edge detection
  logic [1:0] sclMeta_q, sdaMeta_q;
  logic sclSync_q, sdaSync_q, sclPrev_q, sdaPrev_q;
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      sclMeta_q <= 2'h3;
      sdaMeta_q <= 2'h3;
      sclSync_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else begin
      sclMeta_q <= {sclMeta_q[0], serialClockLine};
      sdaMeta_q <= {sdaMeta_q[0], serialDataLineIn};
      sclSync_q <= sclMeta_q[1];
      sdaSync_q <= sdaMeta_q[1];
      sclPrev_q <= sclSync_q;
      sdaPrev_q <= sdaSync_q;
    end
  end
  wire sclRise = sclSync_q & ~sclPrev_q;
  wire sclFall = ~sclSync_q & sclPrev_q;
  wire startCond = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  wire stopCond = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

  cgsm_state_t state_q, state_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [5:0] pos_q, pos_d; // 0 command, 1 count, 2.. data
  logic ackDrive_q, ackDrive_d;
  logic [7:0] cfg_q [CFG_BYTES];
  logic [7:0] cfg_d [CFG_BYTES];
  logic valid_q, valid_d;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    bitCnt_d = bitCnt_q;
    pos_d = pos_q;
    ackDrive_d = ackDrive_q;
    valid_d = 1'b0;
    for (int i = 0; i < CFG_BYTES; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    if (startCond) begin
      state_d = ST_ADDR;
      bitCnt_d = 4'h0;
      ackDrive_d = 1'b0;
    end else if (stopCond) begin
      state_d = ST_IDLE;
      ackDrive_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE, ST_IGNORE: begin
          ackDrive_d = 1'b0;
        end
        ST_ADDR, ST_BYTE: begin
          if (sclRise) begin
            shift_d = {shift_q[6:0], sdaSync_q};
            bitCnt_d = bitCnt_q + 4'h1;
          end
          if (sclFall && bitCnt_q == 4'h8) begin
            bitCnt_d = 4'h0;
            if (state_q == ST_ADDR) begin
              if (shift_q == SLAVE_ADDR_WR) begin
                ackDrive_d = 1'b1;
                pos_d = 6'h0;
                state_d = ST_ACK;
              end else begin
                state_d = ST_IGNORE;
              end
            end else begin
              ackDrive_d = 1'b1;
              state_d = ST_ACK;
              // Command and count are dropped, yet still advance pos
              if (pos_q >= 6'h2 && pos_q < 6'(CFG_BYTES + 2)) begin
                cfg_d[3'(pos_q - 6'h2)] = shift_q;
              end
              if (pos_q == 6'h1) begin
                valid_d = 1'b1;
              end
              if (pos_q != 6'h3F) begin
                pos_d = pos_q + 6'h1;
              end
            end
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            ackDrive_d = 1'b0;
            state_d = ST_BYTE;
          end
        end
        default: begin
          state_d = ST_IDLE;
          ackDrive_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= ST_IDLE;
      shift_q <= 8'h00;
      bitCnt_q <= 4'h0;
      pos_q <= 6'h00;
      ackDrive_q <= 1'b0;
      valid_q <= 1'b0;
      cfg_q[0] <= CFG0_RESET;
      cfg_q[1] <= CFG1_RESET;
      cfg_q[2] <= CFG2_RESET;
      cfg_q[3] <= CFG3_RESET;
      for (int i = 4; i < CFG_BYTES; i++) begin
        cfg_q[i] <= 8'h00;
      end
    end else begin
      state_q <= state_d;
      shift_q <= shift_d;
      bitCnt_q <= bitCnt_d;
      pos_q <= pos_d;
      ackDrive_q <= ackDrive_d;
      valid_q <= valid_d;
      for (int i = 0; i < CFG_BYTES; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
    end
  end

  assign serialDataLineOut = 1'b0;
  assign serialDataLineOen_n = ~ackDrive_q;
  assign transferValid = valid_q;

  // Enables gate the synthesizer; a cleared bit forces its clock low.
  // Spread depth is fixed downward by the synthesizer
  always_comb begin
    ctrl.spreadOn = cfg_q[0][SPREAD_BIT];
    ctrl.dotEn = cfg_q[0][DOT_BIT];
    ctrl.bus48En = cfg_q[0][BUS48_BIT];
    ctrl.hostClockTwoTestPortEn = cfg_q[0][HOST2_BIT];
    ctrl.memoryClockOutputsEn = cfg_q[1];
    ctrl.graphicsFixed66ClockEn = cfg_q[2][GFX_BIT];
    ctrl.expansionBusClockOutputsEn = cfg_q[2][6:1];
    ctrl.mem133Mode = cfg_q[3][MEM133_BIT];
  end
  assign cfgByte3 = cfg_q[3];
endmodule

// >>> dv/cgsm_chk.sv
// Checker for the serial configuration slave, bound to its ports.
// Assumes sys_clk runs far faster than the serial clock.
`timescale 1ns/10ps
module cgsm_chk
  import cgsm_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset
  input wire logic serialClockLine, // Bus clock
  input wire logic serialDataLineIn, // Data wire
  input wire logic serialDataLineOut, // Data drive
  input wire logic serialDataLineOen_n, // Data enable
  input cgsm_ctrl_t ctrl, // Configuration
  input wire logic transferValid, // Count acked
  input wire logic [7:0] cfgByte3 // Byte three
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_pin_low: assert property (!serialDataLineOut)
    else $error("data drive not low");
  a_ack_in_low: assert property ($fell(serialDataLineOen_n)
    |-> !serialClockLine) else $error("ack began with clock high");
  a_ack_shape: assert property ($fell(serialDataLineOen_n)
    |=> !serialDataLineOen_n[*6] ##[1:6] serialDataLineOen_n)
    else $error("ack length wrong");
  a_valid_one: assert property (transferValid |=> !transferValid)
    else $error("valid longer than a cycle");
  a_valid_acked: assert property (transferValid
    |-> ##[0:2] !serialDataLineOen_n) else $error("valid without ack");
  a_ctrl_acked: assert property ($changed(ctrl)
    |-> ##[0:3] !serialDataLineOen_n) else $error("ctrl moved off ack");
  a_cfg3_acked: assert property ($changed(cfgByte3)
    |-> ##[0:3] !serialDataLineOen_n) else $error("byte3 moved off ack");
  a_mode_map: assert property (ctrl.mem133Mode == cfgByte3[0])
    else $error("mode bit not byte3 bit0");
  cover property (transferValid);
  cover property ($changed(cfgByte3));
  cover property ($changed(ctrl.spreadOn));
endmodule
bind cgsm_slave cgsm_chk chk(.sys_clk, .resetn, .serialClockLine,
  .serialDataLineIn, .serialDataLineOut, .serialDataLineOen_n, .ctrl,
  .transferValid, .cfgByte3);

// >>> dv/cgsm_host.sv
// Bus host model: drives the serial clock, pulls the data wire low.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/10ps
module cgsm_host (
  output logic scl, // Serial clock, idle high
  output logic sdaRel, // High releases data
  input wire logic sda // Resolved data wire
);
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end
  // Low phase is long so the slave lets go of its ack before the rise
  task automatic bitTx(input logic b, output logic r);
    #20 sdaRel = b;
    #110 scl = 1'b1;
    #35 r = sda;
    #35 scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] q[$], output logic [5:0] acks);
    logic r;
    acks = 6'h00;
    sdaRel = 1'b0;
    #100 scl = 1'b0;
    foreach (q[k]) begin
      for (int i = 7; i >= 0; i--) bitTx(q[k][i], r);
      bitTx(1'b1, r);
      if (!r) acks++;
    end
    #20 sdaRel = 1'b0;
    #110 scl = 1'b1;
    #50 sdaRel = 1'b1;
    #300;
  endtask
endmodule

// >>> dv/cgsm_slave_test.sv
// Bench for the serial configuration slave: block writes through the
// host model; expected configuration is queued and compared after stop.
`timescale 1ns/10ps
module cgsm_slave_test;
  import cgsm_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic scl, sdaRel, sdaOut, sdaOen_n, tValid;
  wire sda = sdaRel & (sdaOen_n | sdaOut);
  cgsm_ctrl_t ctrl;
  logic [7:0] cfg3, cfg[4], q[$];
  logic [33:0] expQ[$];
  logic [5:0] acks;
  logic [31:0] seed = 32'h0001023C;
  int lens[4] = '{1, 3, 10, 32};
  int err_count = 0;
  int num_checks = 0;
  event doneEv;
  always #12.5 sys_clk = ~sys_clk;
  cgsm_host host(.scl(scl), .sdaRel(sdaRel), .sda(sda));
  cgsm_slave uut(.sys_clk(sys_clk), .resetn(resetn), .serialClockLine(scl),
    .serialDataLineIn(sda), .serialDataLineOut(sdaOut),
    .serialDataLineOen_n(sdaOen_n), .ctrl(ctrl), .transferValid(tValid),
    .cfgByte3(cfg3));
  function automatic logic [27:0] model();
    return {cfg[0][3:0], cfg[1], cfg[2][7:1], cfg[3][0], cfg[3]};
  endfunction
  task automatic run(input logic [7:0] addr, input int cnt);
    logic [7:0] d;
    logic hit;
    hit = (addr == SLAVE_ADDR_WR);
    q = '{addr, 8'h00};
    if (cnt >= 0) q.push_back(cnt[7:0]);
    for (int k = 0; k < cnt; k++) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      d = seed[7:0] & (k == 0 ? 8'h0F : k == 2 ? 8'hFE : k == 1 ? 8'hFF :
        k == 3 ? 8'h01 : 8'h00);
      if (hit && k < 4) cfg[k] = d;
      q.push_back(d);
    end
    host.xfer(q, acks);
    expQ.push_back({hit ? 6'(q.size()) : 6'h00, model()});
    -> doneEv;
  endtask
  task results();
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(doneEv) begin
    num_checks++;
    if ({acks, ctrl, cfg3} !== expQ.pop_front()) begin
      err_count++;
      $display("MISMATCH %0t acks or configuration", $time);
    end
  end
  initial begin
    cfg = '{CFG0_RESET, CFG1_RESET, CFG2_RESET, CFG3_RESET};
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (8) @(posedge sys_clk);
    expQ.push_back({6'h00, model()});
    -> doneEv;
    run(SLAVE_ADDR_WR | 8'h01, 3);
    run(8'hD0, 3);
    run(SLAVE_ADDR_WR, -1);
    foreach (lens[i]) run(SLAVE_ADDR_WR, lens[i]);
    results();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    results();
  end
endmodule
